// file: inc/mclr_defines.svh
`ifndef MCLR_DEFINES_SVH
`define MCLR_DEFINES_SVH

// Byte addresses on the register bus.
`define MCLR_OFS_MCU_CONTROL 12'h000
`define MCLR_OFS_ANALOG_STARTUP_INIT 12'h004
`define MCLR_OFS_EVENT_GROUP_LOCK 12'h008
`define MCLR_OFS_WAVEFORM_EXT_LOCK 12'h00C
`define MCLR_OFS_PROTECT_KEY 12'h010
`define MCLR_OFS_STARTUP_STATUS 12'h014

// Field positions.
`define MCLR_BIT_DEBUG_PORT_DISABLE 0
`define MCLR_BIT_EVENT_LOWER 0
`define MCLR_BIT_EVENT_UPPER 4
`define MCLR_BIT_WAVE_C 0
`define MCLR_BIT_WAVE_E 2

// Writable masks; all other bits are reserved and read zero.
`define MCLR_MASK_MCU_CONTROL 8'h01
`define MCLR_MASK_ANALOG_STARTUP 8'h0F
`define MCLR_MASK_EVENT_LOCK 8'h11
`define MCLR_MASK_WAVE_LOCK 8'h05

`define MCLR_RESET_VALUE 8'h00

// Protection unlock key and the window it stays open, in cycles.
`define MCLR_PROTECT_KEY 8'hD8
`define MCLR_PROTECT_WINDOW 8'h04

// Start-up delay steps in peripheral clock cycles.
`define MCLR_DLY_TWO 6'd2
`define MCLR_DLY_EIGHT 6'd8
`define MCLR_DLY_THIRTYTWO 6'd32

`endif

// file: inc/mclr_pkg.sv
package mclr_pkg;

	typedef enum logic [1:0]
	{
		mclr_seq_idle,
		mclr_seq_ref,
		mclr_seq_bias
	} mclr_seq_state_t;

endpackage : mclr_pkg

// file: core/mclr_seq_start.sv
`timescale 1ns/1ps
`include "mclr_defines.svh"

module mclr_seq_start
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] analog_startup_delay,
	input wire logic module_enable,
	output logic vref_enable,
	output logic bias_enable,
	output logic startup_busy
);
	import mclr_pkg::*;

	typedef struct packed
	{
		mclr_seq_state_t state;
		logic [5:0] count;
		logic vref;
		logic bias;
	} mclr_seq_regs_t;

	mclr_seq_regs_t r;
	mclr_seq_regs_t next_r;
	logic [5:0] step;

	always_comb
	begin
		case (analog_startup_delay)
			2'b01: step = `MCLR_DLY_TWO;
			2'b10: step = `MCLR_DLY_EIGHT;
			2'b11: step = `MCLR_DLY_THIRTYTWO;
			default: step = 6'd0;
		endcase
	end

	always_comb
	begin
		next_r = r;
		if (!module_enable)
		begin
			next_r.state = mclr_seq_idle;
			next_r.vref = 1'b0;
			next_r.bias = 1'b0;
			next_r.count = 6'd0;
		end
		else
		begin
			case (r.state)
				mclr_seq_idle:
				begin
					if (!r.bias)
					begin
						next_r.vref = 1'b1;
						if (step == 6'd0)
						begin
							next_r.bias = 1'b1;
						end
						else
						begin
							// The zero-count cycle and the bias step take one cycle each, so the count is loaded two short of the delay.
							next_r.state = mclr_seq_ref;
							next_r.count = step - 6'd2;
						end
					end
				end
				mclr_seq_ref:
				begin
					if (r.count == 6'd0)
					begin
						next_r.state = mclr_seq_bias;
					end
					else
					begin
						next_r.count = r.count - 6'd1;
					end
				end
				mclr_seq_bias:
				begin
					next_r.bias = 1'b1;
					next_r.state = mclr_seq_idle;
				end
				default: next_r.state = mclr_seq_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign vref_enable = r.vref;
	assign bias_enable = r.bias;
	assign startup_busy = module_enable && !r.bias;

endmodule : mclr_seq_start

// file: core/mclr_regs.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "mclr_defines.svh"

// Operation
// - Setting the debug-port disable bit turns the boundary-scan port off.
// - Disable and lock bits take writes only while the protection window is open.
// - Reserved bits read as zero.
// - A nonzero start-up field enables sequential start of that port's analog parts.
// - With sequential start the reference comes up first and the bias after the delay.
// - Code 00 starts directly, 10 waits 8 cycles and 11 waits 32 cycles.
// - The upper event lock freezes source select and control of channels four to seven.
// - The lower event lock freezes source select and control of channels zero to three.
// - The port-E wave lock freezes the extension on timer E0.
// - The port-C wave lock freezes the extension on timer C0.
module mclr_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [1:0] analog_module_enable,
	output logic [1:0] analog_vref_enable,
	output logic [1:0] analog_bias_enable,
	output logic debug_port_disable,
	output logic event_lower_group_lock,
	output logic event_upper_group_lock,
	output logic wave_ext_port_c_lock,
	output logic wave_ext_port_e_lock,
	output logic [7:0] event_chan_write_block,
	output logic wave_ext_port_c_write_block,
	output logic wave_ext_port_e_write_block
);
	import mclr_pkg::*;

	typedef struct packed
	{
		logic [7:0] mcu_control;
		logic [7:0] analog_startup_init;
		logic [7:0] event_group_lock;
		logic [7:0] waveform_ext_lock;
		logic [7:0] protect_count;
		logic [31:0] rdata;
		logic rd_wait;
	} mclr_regs_t;

	mclr_regs_t r;
	mclr_regs_t next_r;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic open;
	logic [7:0] wbyte;
	logic [1:0] busy;

	assign access = psel && penable;
	assign wr = access && pwrite && pstrb[0];
	assign rd = access && !pwrite;
	assign wbyte = pwdata[7:0];
	assign open = r.protect_count != 8'h00;

	always_comb
	begin
		case (paddr)
			`MCLR_OFS_MCU_CONTROL, `MCLR_OFS_ANALOG_STARTUP_INIT, `MCLR_OFS_EVENT_GROUP_LOCK,
			`MCLR_OFS_WAVEFORM_EXT_LOCK, `MCLR_OFS_PROTECT_KEY, `MCLR_OFS_STARTUP_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		next_r = r;
		if (open)
		begin
			next_r.protect_count = r.protect_count - 8'h01;
		end
		if (wr)
		begin
			case (paddr)
				`MCLR_OFS_PROTECT_KEY:
				begin
					if (wbyte == `MCLR_PROTECT_KEY)
					begin
						next_r.protect_count = `MCLR_PROTECT_WINDOW;
					end
				end
				`MCLR_OFS_MCU_CONTROL:
				begin
					if (open)
					begin
						next_r.mcu_control = wbyte & `MCLR_MASK_MCU_CONTROL;
						next_r.protect_count = 8'h00;
					end
				end
				`MCLR_OFS_ANALOG_STARTUP_INIT:
				begin
					next_r.analog_startup_init = wbyte & `MCLR_MASK_ANALOG_STARTUP;
				end
				`MCLR_OFS_EVENT_GROUP_LOCK:
				begin
					if (open)
					begin
						// Locks only ever set; clearing one needs a reset so a rogue write cannot unfreeze.
						next_r.event_group_lock = r.event_group_lock | (wbyte & `MCLR_MASK_EVENT_LOCK);
						next_r.protect_count = 8'h00;
					end
				end
				`MCLR_OFS_WAVEFORM_EXT_LOCK:
				begin
					if (open)
					begin
						next_r.waveform_ext_lock = r.waveform_ext_lock | (wbyte & `MCLR_MASK_WAVE_LOCK);
						next_r.protect_count = 8'h00;
					end
				end
				default:
				begin
					next_r.rdata = r.rdata;
				end
			endcase
		end
		next_r.rdata = 32'h0000_0000;
		next_r.rd_wait = rd && !r.rd_wait;
		if (rd)
		begin
			case (paddr)
				`MCLR_OFS_MCU_CONTROL: next_r.rdata = {24'h000000, r.mcu_control};
				`MCLR_OFS_ANALOG_STARTUP_INIT: next_r.rdata = {24'h000000, r.analog_startup_init};
				`MCLR_OFS_EVENT_GROUP_LOCK: next_r.rdata = {24'h000000, r.event_group_lock};
				`MCLR_OFS_WAVEFORM_EXT_LOCK: next_r.rdata = {24'h000000, r.waveform_ext_lock};
				`MCLR_OFS_PROTECT_KEY: next_r.rdata = {31'h00000000, open};
				`MCLR_OFS_STARTUP_STATUS: next_r.rdata = {30'h00000000, busy};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_port
			mclr_seq_start u_seq
			(
				.pclk(pclk),
				.presetn(presetn),
				.analog_startup_delay(r.analog_startup_init[2*g+1:2*g]),
				.module_enable(analog_module_enable[g]),
				.vref_enable(analog_vref_enable[g]),
				.bias_enable(analog_bias_enable[g]),
				.startup_busy(busy[g])
			);
		end
	endgenerate

	// Read data lags one cycle, so reads take one wait state; writes finish at once.
	assign pready = !rd || r.rd_wait;
	assign prdata = r.rdata;
	assign pslverr = access && !mapped;

	assign debug_port_disable = r.mcu_control[`MCLR_BIT_DEBUG_PORT_DISABLE];
	assign event_lower_group_lock = r.event_group_lock[`MCLR_BIT_EVENT_LOWER];
	assign event_upper_group_lock = r.event_group_lock[`MCLR_BIT_EVENT_UPPER];
	assign wave_ext_port_c_lock = r.waveform_ext_lock[`MCLR_BIT_WAVE_C];
	assign wave_ext_port_e_lock = r.waveform_ext_lock[`MCLR_BIT_WAVE_E];
	assign event_chan_write_block = {{4{event_upper_group_lock}}, {4{event_lower_group_lock}}};
	assign wave_ext_port_c_write_block = wave_ext_port_c_lock;
	assign wave_ext_port_e_write_block = wave_ext_port_e_lock;

endmodule : mclr_regs

// file: tb/mclr_regs_chk.sv
`timescale 1ns/1ps
module mclr_regs_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic [1:0] analog_module_enable,
	input wire logic [1:0] analog_vref_enable,
	input wire logic debug_port_disable,
	input wire logic event_lower_group_lock,
	input wire logic event_upper_group_lock,
	input wire logic [7:0] event_chan_write_block
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_lower_lock_held: assert property (event_lower_group_lock |=> event_lower_group_lock)
		else $error("lower lock cleared");
	a_upper_lock_held: assert property (event_upper_group_lock |=> event_upper_group_lock)
		else $error("upper lock cleared");
	a_lower_chan_block: assert property (event_lower_group_lock |-> event_chan_write_block[3:0] == 4'hF)
		else $error("low channels open");
	a_upper_chan_block: assert property (event_upper_group_lock |-> event_chan_write_block[7:4] == 4'hF)
		else $error("high channels open");
	a_write_no_wait: assert property (psel && penable && pwrite |-> pready)
		else $error("write waited");
	a_read_upper_zero: assert property (psel && penable && !pwrite && pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_vref_follows: assert property ($rose(analog_module_enable[0]) |=> analog_vref_enable[0])
		else $error("reference late");
	a_debug_by_write: assert property ($changed(debug_port_disable) |-> $past(psel && penable && pwrite))
		else $error("debug bit moved alone");
endmodule : mclr_regs_chk
bind mclr_regs mclr_regs_chk mclr_regs_chk_inst
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.prdata(prdata),
	.analog_module_enable(analog_module_enable),
	.analog_vref_enable(analog_vref_enable),
	.debug_port_disable(debug_port_disable),
	.event_lower_group_lock(event_lower_group_lock),
	.event_upper_group_lock(event_upper_group_lock),
	.event_chan_write_block(event_chan_write_block)
);

// file: tb/mclr_regs_test.sv
`timescale 1ns/1ps
`include "mclr_defines.svh"
module mclr_regs_test;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, debug_port_disable, event_lower_group_lock, event_upper_group_lock;
	logic wave_ext_port_c_lock, wave_ext_port_e_lock, wave_ext_port_c_write_block, wave_ext_port_e_write_block;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, f, seed = 32'h33;
	logic err;
	logic [3:0] pstrb = 4'hF;
	logic [1:0] analog_module_enable = 2'h0, analog_vref_enable, analog_bias_enable;
	logic [7:0] event_chan_write_block;
	int num_errors = 0, checks = 0, n, n1;
	mclr_regs mclr_regs_inst
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.analog_module_enable(analog_module_enable),
		.analog_vref_enable(analog_vref_enable),
		.analog_bias_enable(analog_bias_enable),
		.debug_port_disable(debug_port_disable),
		.event_lower_group_lock(event_lower_group_lock),
		.event_upper_group_lock(event_upper_group_lock),
		.wave_ext_port_c_lock(wave_ext_port_c_lock),
		.wave_ext_port_e_lock(wave_ext_port_e_lock),
		.event_chan_write_block(event_chan_write_block),
		.wave_ext_port_c_write_block(wave_ext_port_c_write_block),
		.wave_ext_port_e_write_block(wave_ext_port_e_write_block)
	);
	always #5 pclk = ~pclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Cycles from reference to bias for each start-up code.
	function automatic logic [31:0] dly(int c);
		case (c)
			1: return 32'd2;
			2: return 32'd8;
			3: return 32'd32;
			default: return 32'd0;
		endcase
	endfunction : dly
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic step(input logic k, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		if (k)
			xfer(1'b1, `MCLR_OFS_PROTECT_KEY, {24'h0, `MCLR_PROTECT_KEY});
		xfer(1'b1, a, d);
		xfer(1'b0, a, 32'h0);
		cmp("register", e, rd);
		cmp("no slverr", 32'h0, err);
	endtask : step
	task automatic final_report();
		$display("Counts: %0d checks, %0d errors", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 24; a += 4)
			step(1'b0, 12'(a), 32'h0, 32'h0);
		$display("done: reset values");
		step(1'b0, 12'h0, 32'h1, 32'h0);
		xfer(1'b1, `MCLR_OFS_PROTECT_KEY, {24'h0, `MCLR_PROTECT_KEY});
		xfer(1'b1, 12'h0, 32'h1);
		step(1'b0, 12'h0, 32'h0, 32'h1);
		cmp("debug", 32'h1, debug_port_disable);
		step(1'b1, 12'h0, 32'h0, 32'h0);
		$display("done: debug disable");
		step(1'b1, 12'h8, 32'h10, 32'h10);
		cmp("block", 32'hF0, event_chan_write_block);
		step(1'b1, 12'h8, 32'h1, 32'h11);
		step(1'b1, 12'h8, 32'h0, 32'h11);
		cmp("block", 32'hFF, event_chan_write_block);
		cmp("event locks", 32'h3, {event_upper_group_lock, event_lower_group_lock});
		step(1'b1, 12'hC, 32'h4, 32'h4);
		cmp("wave", 32'h2, {wave_ext_port_e_write_block, wave_ext_port_c_write_block});
		step(1'b1, 12'hC, 32'h1, 32'h5);
		cmp("wave", 32'h3, {wave_ext_port_e_lock, wave_ext_port_c_lock});
		$display("done: locks");
		xfer(1'b0, 12'h018, 32'h0);
		cmp("unmapped", 32'h0, rd);
		cmp("slverr", 32'h1, err);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		step(1'b0, 12'h8, 32'h0, 32'h0);
		cmp("block", 32'h0, event_chan_write_block);
		cmp("wave", 32'h0, {wave_ext_port_e_lock, wave_ext_port_c_lock});
		$display("done: reset clears locks");
		// Even the longest delay is short of half a microsecond at this clock; every code is still run.
		for (int c = 0; c < 4; c++)
		begin
			f = rnd() & 32'h3;
			step(1'b0, 12'h4, (f << 2) | 32'(c), (f << 2) | 32'(c));
			analog_module_enable <= 2'h3;
			n = 0;
			n1 = 0;
			repeat (60)
			begin
				@(negedge pclk);
				if (analog_vref_enable[0] === 1'b1 && analog_bias_enable[0] !== 1'b1)
					n++;
				if (analog_vref_enable[1] === 1'b1 && analog_bias_enable[1] !== 1'b1)
					n1++;
			end
			cmp("bias delay", dly(c), n);
			cmp("bias delay upper", dly(int'(f)), n1);
			xfer(1'b0, `MCLR_OFS_STARTUP_STATUS, 32'h0);
			cmp("status", 32'h0, rd);
			cmp("analog on", 32'hF, {analog_vref_enable, analog_bias_enable});
			@(posedge pclk);
			analog_module_enable <= 2'h0;
			repeat (3) @(posedge pclk);
		end
		$display("done: start-up");
		final_report();
	end
	initial
	begin
		#100000;
		num_errors++;
		final_report();
	end
endmodule : mclr_regs_test
